// ---- hdl/lpd_phy_ctrl.sv ----
`timescale 1ns/10ps
`include "lpd_regs.svh"
// Notes on behaviour
// - Two-bit slew select picks 10.4k, 20k or fast; resets to 20k.
// - Cleared pull-up enable drops pull-up in low power and switches wake threshold.
// - Over-current keeps transmitter on and sets over-current flag.
// - Any bus flag with bus interrupt mask set drives interrupt low.
// - Over-temperature shuts transmitter and sets over-temperature flag.
// - After over-temperature, transmitter returns when condition gone, transmit high and receive-only cleared.
// - Status read clears over-temperature flag only if over-temperature is gone.
// - Receive pin short sets short flag and shuts transmitter.
// - After short, transmitter returns on receive transition with transmit high, once receive-only cleared.
// - Status read clears short flag only if short is gone.
// - Transmit low over one second shuts transmitter, sets stuck flag.
// - Stuck shutdown ends when transmit high; read with transmit high clears flag.
// - Dominant-level select bit picks bus dominant voltage level.
// - Receive-only disables driver in normal mode; set by over-temperature, short or stuck, not over-current.
// - Low power with receive-only disables wake; stop mode receive follows bus.
// - Stop mode: long dominant then rising edge raises wake interrupt, recorded.
// - Sleep mode: long dominant then rising edge wakes system with reset, recorded.
// - One-byte frame: address, control in; summary, blank, status out.
// - Chip select fall starts frame, drives output, latches read data.
// - Shift out on rising clock, sample on falling clock.
// - Frame valid only with exactly eight sampling edges.
// - Chip select rise commits write; output floats while deselected.
// - Power-on, reset mode or reset pin restore register reset values, except battery fail flag.
// - Address 4 bus control write, address 5 bus status read.
// - Status bits: short 3, stuck 2, over-temp 1, over-current 0.
// - Summary bits in every frame, each the OR of its register.
// - Bus interrupt mask is bit 1 of mask register at address E.

module lpd_phy_ctrl #(
	parameter int unsigned STUCK_CYC = `LPD_STUCK_CYC,
	parameter int unsigned WAKE_CYC  = `LPD_WAKE_CYC
) (
	// Clock and resets
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	input  wire logic        por_in,
	input  wire logic        reset_mode_in,
	input  wire logic        ext_reset_n_in,
	// SPI pins
	input  wire logic        cs_n_in,
	input  wire logic        sclk_in,
	input  wire logic        mosi_in,
	output logic             miso_out,
	output logic             miso_oe_n_out,
	// Transceiver side
	input  wire logic        txd_in,
	input  wire logic        bus_in,
	input  wire logic        rxd_pin_in,
	input  wire logic        overcurrent_in,
	input  wire logic        overtemp_in,
	input  wire logic        rxd_short_in,
	output logic             tx_enable_out,
	output logic             rxd_follow_out,
	output logic [1:0]       slew_select_out,
	output logic             dominant_level_select_out,
	output logic             bus_pullup_bit_out,
	output logic             alt_wake_threshold_out,
	// System status inputs
	input  wire logic [3:0]  volt_status_in,
	input  wire logic [3:0]  switch_status_in,
	input  wire logic [3:0]  other_isrc_in,
	// Mode and events
	output lpd_pkg::lpd_mode_t mode_out,
	output logic             irq_n_out,
	output logic             wake_irq_out,
	output logic             wake_reset_out
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	logic [6:0] s1_r, s2_r;
	logic [6:0] s1_nxt, s2_nxt;
	logic       txd_s, bus_s, rxp_s, oc_s, ot_s, sh_s, ext_n_s;

	always_comb begin
		s1_nxt = {ext_reset_n_in, rxd_short_in, overtemp_in, overcurrent_in,
			rxd_pin_in, bus_in, txd_in};
		s2_nxt = s1_r;
		{ext_n_s, sh_s, ot_s, oc_s, rxp_s, bus_s, txd_s} = s2_r;
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s1_r <= 7'h47;
			s2_r <= 7'h47;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// ****************************************
	// SPI shifter
	// ****************************************
	lpd_pkg::lpd_spi_cmd_t cmd;
	logic                  frame_start;
	logic [7:0]            read_byte;

	lpd_spi_slave u_spi (
		.clock_in      (clock_in),
		.reset_n_in    (reset_n_in),
		.cs_n_in       (cs_n_in),
		.sclk_in       (sclk_in),
		.mosi_in       (mosi_in),
		.miso_out      (miso_out),
		.miso_oe_n_out (miso_oe_n_out),
		.read_byte_in  (read_byte),
		.start_out     (frame_start),
		.cmd_out       (cmd)
	);

	// ****************************************
	// Registers and protection
	// ****************************************
	lpd_pkg::lpd_bus_ctrl_t ctrl_r, ctrl_nxt;
	lpd_pkg::lpd_bus_stat_t stat_r, stat_nxt;
	lpd_pkg::lpd_mode_t     mode_r, mode_nxt;
	logic [3:0]  imask_r, imask_nxt;
	logic        pullup_r, pullup_nxt;
	logic        battery_fail_flag_r, battery_fail_flag_nxt;
	logic        ot_off_r, ot_off_nxt;
	logic        sh_off_r, sh_off_nxt;
	logic        dom_off_r, dom_off_nxt;
	logic [31:0] low_cnt_r, low_cnt_nxt;
	logic [31:0] wk_cnt_r, wk_cnt_nxt;
	logic        wk_armed_r, wk_armed_nxt;
	logic        wake_src_r, wake_src_nxt;
	logic        wake_irq_r, wake_irq_nxt;
	logic        wake_rst_r, wake_rst_nxt;
	logic        rxp_d_r, rxp_d_nxt;
	logic [3:0]  addr_r, addr_nxt;
	logic        soft_rst, stat_read, low_power, err_event;

	function automatic logic any_set(input logic [3:0] v);
		any_set = |v;
	endfunction

	// Byte returned on each frame
	always_comb begin
		logic [3:0] body;
		body = 4'h0;
		case (addr_r)
			`LPD_ADDR_MODE, `LPD_ADDR_VOLT: body = {volt_status_in[3:1], battery_fail_flag_r};
			`LPD_ADDR_BUS_CTRL, `LPD_ADDR_BUS_STAT: body = stat_r;
			`LPD_ADDR_IMASK, `LPD_ADDR_ISRC: body = {other_isrc_in[3:2], wake_src_r,
				other_isrc_in[0]};
			default: body = 4'h0;
		endcase
		read_byte = {any_set({volt_status_in[3:1], battery_fail_flag_r}), any_set(stat_r),
			any_set(switch_status_in), 1'b0, body};
	end

	always_comb begin
		soft_rst     = por_in | reset_mode_in | ~ext_n_s;
		// Reads answer for the address of the last valid frame
		addr_nxt     = addr_r;
		if (cmd.wr) begin
			addr_nxt = cmd.addr;
		end
		stat_read    = frame_start &&
			(addr_r == `LPD_ADDR_BUS_CTRL || addr_r == `LPD_ADDR_BUS_STAT);
		ctrl_nxt     = ctrl_r;
		imask_nxt    = imask_r;
		pullup_nxt   = pullup_r;
		mode_nxt     = mode_r;
		battery_fail_flag_nxt  = battery_fail_flag_r | por_in;
		rxp_d_nxt    = rxp_s;
		low_power    = mode_r != lpd_pkg::LPD_NORMAL;
		if (cmd.wr) begin
			case (cmd.addr)
				`LPD_ADDR_BUS_CTRL: ctrl_nxt = cmd.data;
				`LPD_ADDR_IMASK: imask_nxt = cmd.data;
				`LPD_ADDR_MODE: begin
					pullup_nxt = cmd.data[`LPD_MODE_PU_BIT];
					case (cmd.data[1:0])
						2'h1: mode_nxt = lpd_pkg::LPD_STOP;
						2'h2: mode_nxt = lpd_pkg::LPD_SLEEP;
						default: mode_nxt = lpd_pkg::LPD_NORMAL;
					endcase
				end
				default: ;
			endcase
		end
		// Stuck-dominant timer
		low_cnt_nxt = txd_s ? 32'h0 : (low_cnt_r == STUCK_CYC ? low_cnt_r : low_cnt_r + 32'h1);
		// Flags: a new event beats a read clear
		stat_nxt = stat_r;
		if (stat_read) begin
			if (!sh_s) stat_nxt.receive_pin_short_flag = 1'b0;
			if (txd_s) stat_nxt.stuck_dominant_flag = 1'b0;
			stat_nxt.bus_overtemp_flag    = ot_s;
			stat_nxt.bus_overcurrent_flag = oc_s;
		end
		if (oc_s) stat_nxt.bus_overcurrent_flag = 1'b1;
		if (ot_s) stat_nxt.bus_overtemp_flag = 1'b1;
		if (sh_s) stat_nxt.receive_pin_short_flag = 1'b1;
		if (low_cnt_r == STUCK_CYC) stat_nxt.stuck_dominant_flag = 1'b1;
		ot_off_nxt  = ot_off_r;
		if (ot_s) ot_off_nxt = 1'b1;
		else if (txd_s) ot_off_nxt = 1'b0;
		sh_off_nxt  = sh_off_r;
		if (sh_s) sh_off_nxt = 1'b1;
		else if (txd_s && (rxp_s != rxp_d_r)) sh_off_nxt = 1'b0;
		dom_off_nxt = dom_off_r;
		if (low_cnt_r == STUCK_CYC) dom_off_nxt = 1'b1;
		else if (txd_s) dom_off_nxt = 1'b0;
		err_event = ot_s | sh_s | (low_cnt_r == STUCK_CYC);
		if (err_event) ctrl_nxt.receive_only = 1'b1;
		// Bus wake detector
		wk_cnt_nxt   = bus_s ? 32'h0 : (wk_cnt_r == WAKE_CYC ? wk_cnt_r : wk_cnt_r + 32'h1);
		wk_armed_nxt = wk_armed_r;
		wake_irq_nxt = 1'b0;
		wake_rst_nxt = 1'b0;
		wake_src_nxt = wake_src_r;
		if (!low_power || ctrl_r.receive_only) begin
			wk_armed_nxt = 1'b0;
		end else if (wk_cnt_r == WAKE_CYC) begin
			wk_armed_nxt = 1'b1;
		end else if (wk_armed_r && bus_s) begin
			wk_armed_nxt = 1'b0;
			wake_src_nxt = 1'b1;
			mode_nxt     = lpd_pkg::LPD_NORMAL;
			if (mode_r == lpd_pkg::LPD_STOP) wake_irq_nxt = 1'b1;
			else wake_rst_nxt = 1'b1;
		end
		if (frame_start && (addr_r == `LPD_ADDR_IMASK || addr_r == `LPD_ADDR_ISRC) &&
				!(wk_armed_r && bus_s)) begin
			wake_src_nxt = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_r     <= '{1'b0, 1'b0, `LPD_SLEW_RESET};
			stat_r     <= '0;
			mode_r     <= lpd_pkg::LPD_NORMAL;
			imask_r    <= `LPD_IMASK_RESET;
			pullup_r   <= 1'b1;
			battery_fail_flag_r  <= 1'b1;
			ot_off_r   <= 1'b0;
			sh_off_r   <= 1'b0;
			dom_off_r  <= 1'b0;
			low_cnt_r  <= 32'h0;
			wk_cnt_r   <= 32'h0;
			wk_armed_r <= 1'b0;
			wake_src_r <= 1'b0;
			wake_irq_r <= 1'b0;
			wake_rst_r <= 1'b0;
			rxp_d_r    <= 1'b1;
			addr_r     <= 4'h0;
		end else if (soft_rst) begin
			// Register contents except battery fail flag return to reset values; pins keep tracking
			ctrl_r     <= '{1'b0, 1'b0, `LPD_SLEW_RESET};
			stat_r     <= '0;
			mode_r     <= lpd_pkg::LPD_NORMAL;
			imask_r    <= `LPD_IMASK_RESET;
			pullup_r   <= 1'b1;
			battery_fail_flag_r  <= battery_fail_flag_nxt;
			ot_off_r   <= 1'b0;
			sh_off_r   <= 1'b0;
			dom_off_r  <= 1'b0;
			low_cnt_r  <= 32'h0;
			wk_cnt_r   <= 32'h0;
			wk_armed_r <= 1'b0;
			wake_src_r <= 1'b0;
			wake_irq_r <= 1'b0;
			wake_rst_r <= 1'b0;
			rxp_d_r    <= rxp_d_nxt;
			addr_r     <= 4'h0;
		end else begin
			ctrl_r     <= ctrl_nxt;
			stat_r     <= stat_nxt;
			mode_r     <= mode_nxt;
			imask_r    <= imask_nxt;
			pullup_r   <= pullup_nxt;
			battery_fail_flag_r  <= battery_fail_flag_nxt;
			ot_off_r   <= ot_off_nxt;
			sh_off_r   <= sh_off_nxt;
			dom_off_r  <= dom_off_nxt;
			low_cnt_r  <= low_cnt_nxt;
			wk_cnt_r   <= wk_cnt_nxt;
			wk_armed_r <= wk_armed_nxt;
			wake_src_r <= wake_src_nxt;
			wake_irq_r <= wake_irq_nxt;
			wake_rst_r <= wake_rst_nxt;
			rxp_d_r    <= rxp_d_nxt;
			addr_r     <= addr_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign tx_enable_out = !low_power && !ctrl_r.receive_only && !ot_off_r &&
		!sh_off_r && !dom_off_r;
	assign rxd_follow_out = mode_r == lpd_pkg::LPD_STOP && ctrl_r.receive_only;
	assign slew_select_out           = ctrl_r.slew_select;
	assign dominant_level_select_out = ctrl_r.dominant_level_select;
	assign bus_pullup_bit_out        = pullup_r || !low_power;
	assign alt_wake_threshold_out    = !pullup_r;
	assign mode_out       = mode_r;
	assign irq_n_out      = !(imask_r[`LPD_IMR_BUS_BIT] && any_set(stat_r));
	assign wake_irq_out   = wake_irq_r;
	assign wake_reset_out = wake_rst_r;
endmodule

// ---- hdl/lpd_regs.svh ----
`ifndef LPD_REGS_SVH
`define LPD_REGS_SVH

// SPI register addresses
`define LPD_ADDR_MODE        4'h0
`define LPD_ADDR_VOLT        4'h1
`define LPD_ADDR_BUS_CTRL    4'h4
`define LPD_ADDR_BUS_STAT    4'h5
`define LPD_ADDR_IMASK       4'he
`define LPD_ADDR_ISRC        4'hf

// Bus control, mode and mask field positions
`define LPD_BC_DOM_BIT       3
`define LPD_BC_RECEIVE_ONLY_BIT    2
`define LPD_MODE_PU_BIT      2
`define LPD_IMR_BUS_BIT      1

// Reset values
`define LPD_SLEW_RESET       2'h1
`define LPD_MODE_RESET       4'hc
`define LPD_IMASK_RESET      4'h0

// Slew encodings
`define LPD_SLEW_10K4        2'h0
`define LPD_SLEW_20K         2'h1
`define LPD_SLEW_FAST        2'h2

// Timing
`define LPD_CLK_HZ           40000000
`define LPD_STUCK_MS         1000
`define LPD_STUCK_CYC        ((`LPD_CLK_HZ / 1000) * `LPD_STUCK_MS)
`define LPD_WAKE_US          30
`define LPD_WAKE_CYC         ((`LPD_CLK_HZ / 1000000) * `LPD_WAKE_US)
`define LPD_SPI_BITS         8

`endif

// ---- hdl/lpd_pkg.sv ----
package lpd_pkg;
	typedef enum logic [1:0] {
		LPD_NORMAL,
		LPD_STOP,
		LPD_SLEEP
	} lpd_mode_t;

	typedef struct packed {
		logic receive_pin_short_flag;
		logic stuck_dominant_flag;
		logic bus_overtemp_flag;
		logic bus_overcurrent_flag;
	} lpd_bus_stat_t;

	typedef struct packed {
		logic       dominant_level_select;
		logic       receive_only;
		logic [1:0] slew_select;
	} lpd_bus_ctrl_t;

	typedef struct packed {
		logic       wr;
		logic [3:0] addr;
		logic [3:0] data;
	} lpd_spi_cmd_t;
endpackage

// ---- hdl/lpd_spi_slave.sv ----
`timescale 1ns/10ps
`include "lpd_regs.svh"

module lpd_spi_slave (
	// Clock and reset
	input  wire logic                clock_in,
	input  wire logic                reset_n_in,
	// SPI pins
	input  wire logic                cs_n_in,
	input  wire logic                sclk_in,
	input  wire logic                mosi_in,
	output logic                     miso_out,
	output logic                     miso_oe_n_out,
	// Register side
	input  wire logic [7:0]          read_byte_in,
	output logic                     start_out,
	output lpd_pkg::lpd_spi_cmd_t    cmd_out
);
	logic [1:0] cs_sync_r, cs_sync_nxt;
	logic [1:0] sck_sync_r, sck_sync_nxt;
	logic [1:0] mo_sync_r, mo_sync_nxt;
	logic       cs_d_r, cs_d_nxt;
	logic       sck_d_r, sck_d_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic [7:0] rx_r, rx_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       miso_r, miso_nxt;
	logic       oe_n_r, oe_n_nxt;
	logic       start_nxt;
	lpd_pkg::lpd_spi_cmd_t cmd_r, cmd_nxt;
	logic       cs_fall, cs_rise, sck_rise, sck_fall;

	always_comb begin
		cs_sync_nxt  = {cs_sync_r[0], cs_n_in};
		sck_sync_nxt = {sck_sync_r[0], sclk_in};
		mo_sync_nxt  = {mo_sync_r[0], mosi_in};
		cs_d_nxt     = cs_sync_r[1];
		sck_d_nxt    = sck_sync_r[1];
		cs_fall      = cs_d_r & ~cs_sync_r[1];
		cs_rise      = ~cs_d_r & cs_sync_r[1];
		sck_rise     = ~sck_d_r & sck_sync_r[1];
		sck_fall     = sck_d_r & ~sck_sync_r[1];
		tx_nxt       = tx_r;
		rx_nxt       = rx_r;
		cnt_nxt      = cnt_r;
		miso_nxt     = miso_r;
		oe_n_nxt     = oe_n_r;
		start_nxt    = 1'b0;
		cmd_nxt      = cmd_r;
		cmd_nxt.wr   = 1'b0;
		if (cs_fall) begin
			// Read data latched at frame start, MSB shown at once
			tx_nxt    = read_byte_in;
			miso_nxt  = read_byte_in[7];
			oe_n_nxt  = 1'b0;
			cnt_nxt   = 4'h0;
			start_nxt = 1'b1;
		end else if (!cs_sync_r[1]) begin
			if (sck_rise && cnt_r != 4'h0) begin
				miso_nxt = tx_r[7];
			end
			if (sck_fall) begin
				rx_nxt = {rx_r[6:0], mo_sync_r[1]};
				tx_nxt = {tx_r[6:0], 1'b0};
				if (cnt_r != 4'hf) begin
					cnt_nxt = cnt_r + 4'h1;
				end
			end
		end
		if (cs_rise) begin
			oe_n_nxt = 1'b1;
			// Any count but eight drops the byte
			if (cnt_r == 4'(`LPD_SPI_BITS)) begin
				cmd_nxt.wr   = 1'b1;
				cmd_nxt.addr = rx_r[7:4];
				cmd_nxt.data = rx_r[3:0];
			end
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			// Clock idles high; a low reset value would fake a rising edge
			cs_sync_r  <= 2'h3;
			sck_sync_r <= 2'h3;
			mo_sync_r  <= 2'h0;
			cs_d_r     <= 1'b1;
			sck_d_r    <= 1'b1;
			tx_r       <= 8'h00;
			rx_r       <= 8'h00;
			cnt_r      <= 4'h0;
			miso_r     <= 1'b0;
			oe_n_r     <= 1'b1;
			start_out  <= 1'b0;
			cmd_r      <= '0;
		end else begin
			cs_sync_r  <= cs_sync_nxt;
			sck_sync_r <= sck_sync_nxt;
			mo_sync_r  <= mo_sync_nxt;
			cs_d_r     <= cs_d_nxt;
			sck_d_r    <= sck_d_nxt;
			tx_r       <= tx_nxt;
			rx_r       <= rx_nxt;
			cnt_r      <= cnt_nxt;
			miso_r     <= miso_nxt;
			oe_n_r     <= oe_n_nxt;
			start_out  <= start_nxt;
			cmd_r      <= cmd_nxt;
		end
	end

	assign miso_out      = miso_r;
	assign miso_oe_n_out = oe_n_r;
	assign cmd_out       = cmd_r;
endmodule

// ---- verif/lpd_phy_ctrl_properties.sv ----
`timescale 1ns/10ps
module lpd_phy_ctrl_properties #(
	parameter int unsigned STUCK_CYC = 200,
	parameter int unsigned WAKE_CYC  = 20
) (
	input wire logic               clock_in,
	input wire logic               reset_n_in,
	input wire logic               por_in,
	input wire logic               cs_n_in,
	input wire logic               txd_in,
	input wire logic               overtemp_in,
	input wire logic               rxd_short_in,
	input wire logic               miso_oe_n_out,
	input wire logic               tx_enable_out,
	input wire logic               rxd_follow_out,
	input wire logic [1:0]         slew_select_out,
	input wire lpd_pkg::lpd_mode_t mode_out,
	input wire logic               wake_irq_out,
	input wire logic               wake_reset_out
);
	// ******
	// Stuck-low counter
	// ******
	logic [31:0] low_cnt_r;
	logic [31:0] low_cnt_nxt;

	always_comb begin
		low_cnt_nxt = txd_in ? 32'h0 : low_cnt_r + 32'h1;
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_cnt_r <= 32'h0;
		end else begin
			low_cnt_r <= low_cnt_nxt;
		end
	end

	// ******
	// Properties
	// ******
	default clocking @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);

	// Six cycles leave slack for the two-flop synchroniser
	sequence s_cs_idle;
		cs_n_in [*6];
	endsequence
	sequence s_cs_busy;
		!cs_n_in [*6];
	endsequence

	a_oe_idle: assert property (s_cs_idle |-> miso_oe_n_out)
		else $error("serial output driven while deselected");
	a_oe_frame: assert property (s_cs_busy |-> !miso_oe_n_out)
		else $error("serial output floating inside a frame");
	a_temp_stop: assert property (overtemp_in [*5] |-> !tx_enable_out)
		else $error("transmitter on during over-temperature");
	a_short_stop: assert property (rxd_short_in [*5] |-> !tx_enable_out)
		else $error("transmitter on during receive short");
	a_stuck_stop: assert property (low_cnt_r > STUCK_CYC + 5 |-> !tx_enable_out)
		else $error("transmitter on after stuck dominant");
	a_wake_pulse: assert property (wake_irq_out |=> !wake_irq_out)
		else $error("wake interrupt longer than one cycle");
	a_reset_pulse: assert property (wake_reset_out |=> !wake_reset_out)
		else $error("wake reset longer than one cycle");
	a_por_slew: assert property (por_in [*2] |=> slew_select_out == 2'h1)
		else $error("slew select not restored by power-on reset");
	a_follow_stop: assert property (rxd_follow_out |-> mode_out == lpd_pkg::LPD_STOP)
		else $error("receive follow outside stop mode");
endmodule

bind lpd_phy_ctrl lpd_phy_ctrl_properties #(
	.STUCK_CYC(STUCK_CYC),
	.WAKE_CYC(WAKE_CYC)
) i_props (
	.clock_in,
	.reset_n_in,
	.por_in,
	.cs_n_in,
	.txd_in,
	.overtemp_in,
	.rxd_short_in,
	.miso_oe_n_out,
	.tx_enable_out,
	.rxd_follow_out,
	.slew_select_out,
	.mode_out,
	.wake_irq_out,
	.wake_reset_out
);

// ---- verif/lpd_spi_master.sv ----
`timescale 1ns/10ps
module lpd_spi_master (
	// SPI pins
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      mosi_out,
	input  wire logic miso_in
);
	// ******
	// Frame engine
	// ******
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		mosi_out = 1'b0;
	end

	// Clock idles high and stands still between frames
	task automatic frame(input logic [7:0] tx, input int edges, output logic [7:0] rx);
		logic [7:0] sh;
		sh = tx;
		rx = 8'h00;
		cs_n_out = 1'b0;
		mosi_out = sh[7];
		#200;
		for (int i = 0; i < edges; i++) begin
			sclk_out = 1'b0;
			rx = {rx[6:0], miso_in};
			#75;
			sclk_out = 1'b1;
			sh = {sh[6:0], 1'b0};
			mosi_out = sh[7];
			#125;
		end
		#100;
		cs_n_out = 1'b1;
		// Released line shows inverse, never a stale value
		mosi_out = ~mosi_out;
	endtask
endmodule

// ---- verif/test_lpd_phy_ctrl.sv ----
`timescale 1ns/10ps
module test_lpd_phy_ctrl;
	localparam int unsigned STUCK = 200;
	localparam int unsigned WAKE  = 20;

	logic clock_in = 1'b0, reset_n_in = 1'b0, por_in = 1'b0, reset_mode_in = 1'b0;
	logic ext_reset_n_in = 1'b1, txd_in = 1'b1, bus_in = 1'b1, rxd_pin_in = 1'b1;
	logic overcurrent_in = 1'b0, overtemp_in = 1'b0, rxd_short_in = 1'b0;
	logic [3:0] volt_status_in = 4'h1, switch_status_in = 4'h0, other_isrc_in = 4'h0;
	logic cs_n_in, sclk_in, mosi_in, miso_out, miso_oe_n_out, tx_enable_out;
	logic rxd_follow_out, dominant_level_select_out, alt_wake_threshold_out;
	logic bus_pullup_bit_out;
	logic irq_n_out, wake_irq_out, wake_reset_out;
	logic [1:0] slew_select_out;
	lpd_pkg::lpd_mode_t mode_out;
	wire miso_w = miso_oe_n_out ? ~miso_out : miso_out;
	int failures = 0, compares = 0, wakes = 0, resets = 0;

	always #12.5 clock_in = ~clock_in;
	always @(negedge clock_in) begin
		if (wake_irq_out === 1'b1) wakes++;
		if (wake_reset_out === 1'b1) resets++;
	end

	lpd_spi_master i_mcu (.cs_n_out(cs_n_in), .sclk_out(sclk_in), .mosi_out(mosi_in),
		.miso_in(miso_w));
	lpd_phy_ctrl #(.STUCK_CYC(STUCK), .WAKE_CYC(WAKE)) i_dut (.clock_in, .reset_n_in,
		.por_in, .reset_mode_in, .ext_reset_n_in, .cs_n_in, .sclk_in, .mosi_in,
		.miso_out, .miso_oe_n_out, .txd_in, .bus_in, .rxd_pin_in, .overcurrent_in,
		.overtemp_in, .rxd_short_in, .tx_enable_out, .rxd_follow_out, .slew_select_out,
		.dominant_level_select_out, .bus_pullup_bit_out, .alt_wake_threshold_out,
		.volt_status_in, .switch_status_in, .other_isrc_in, .mode_out, .irq_n_out,
		.wake_irq_out, .wake_reset_out);

	// ******
	// Tasks
	// ******
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#2;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic spi(input logic [3:0] a, input logic [3:0] d, input int e,
		output logic [7:0] rx);
		i_mcu.frame({a, d}, e, rx);
		step(8);
	endtask

	task automatic wr(input logic [3:0] a, input logic [3:0] d);
		logic [7:0] rx;
		spi(a, d, 8, rx);
	endtask

	// Answer belongs to the previous frame's address, hence two frames
	task automatic rd(output logic [7:0] rx);
		spi(4'h5, 4'h0, 8, rx);
		spi(4'h5, 4'h0, 8, rx);
		rx[4] = 1'b0;
	endtask

	task automatic wait_tx;
		int n;
		n = 0;
		while (tx_enable_out !== 1'b1 && n < 400) begin
			step(1);
			n++;
		end
		if (n == 400) begin
			failures++;
			$display("mismatch at %0t: transmitter never re-enabled", $time);
			give_verdict();
		end
	endtask

	task automatic dominant(input int n);
		bus_in = 1'b0;
		step(n);
		bus_in = 1'b1;
		step(40);
	endtask

	task automatic give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// ******
	// Sequence
	// ******
	initial begin
		logic [7:0] rx;
		step(12);
		reset_n_in = 1'b1;
		step(4);
		check({5'h0, irq_n_out, tx_enable_out, miso_oe_n_out}, 8'h07);
		check({6'h0, slew_select_out}, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr(4'h4, {i[0], 1'b0, i[1:0]});
			check({5'h0, dominant_level_select_out, slew_select_out}, {5'h0, i[0], i[1:0]});
		end
		spi(4'h4, 4'h1, 7, rx);
		spi(4'h4, 4'h1, 9, rx);
		check({6'h0, slew_select_out}, 8'h02);
		wr(4'h4, 4'h5);
		check({7'h0, tx_enable_out}, 8'h00);
		wr(4'h4, 4'h1);
		overcurrent_in = 1'b1;
		step(6);
		check({6'h0, tx_enable_out, irq_n_out}, 8'h03);
		wr(4'he, 4'h2);
		check({7'h0, irq_n_out}, 8'h00);
		rd(rx);
		check(rx, 8'hc1);
		overcurrent_in = 1'b0;
		rd(rx);
		check(rx, 8'h80);
		overtemp_in = 1'b1;
		step(6);
		check({7'h0, tx_enable_out}, 8'h00);
		rd(rx);
		check(rx, 8'hc2);
		overtemp_in = 1'b0;
		step(6);
		check({7'h0, tx_enable_out}, 8'h00);
		wr(4'h4, 4'h1);
		wait_tx();
		rd(rx);
		check(rx, 8'h80);
		txd_in = 1'b0;
		step(STUCK - 20);
		check({7'h0, tx_enable_out}, 8'h01);
		step(40);
		check({7'h0, tx_enable_out}, 8'h00);
		rd(rx);
		check(rx, 8'hc4);
		txd_in = 1'b1;
		wr(4'h4, 4'h1);
		wait_tx();
		rd(rx);
		check(rx, 8'h80);
		rxd_short_in = 1'b1;
		step(6);
		check({7'h0, tx_enable_out}, 8'h00);
		rd(rx);
		check(rx, 8'hc8);
		rxd_short_in = 1'b0;
		step(6);
		wr(4'h4, 4'h1);
		check({7'h0, tx_enable_out}, 8'h00);
		rxd_pin_in = 1'b0;
		step(4);
		rxd_pin_in = 1'b1;
		wait_tx();
		switch_status_in = 4'h8;
		rd(rx);
		check(rx, 8'ha0);
		check({7'h0, irq_n_out}, 8'h01);
		wr(4'h0, 4'h1);
		check({4'h0, bus_pullup_bit_out, alt_wake_threshold_out, mode_out}, 8'h05);
		dominant(WAKE - 10);
		check(wakes[7:0], 8'h00);
		dominant(WAKE + 10);
		check({wakes[5:0], mode_out}, 8'h04);
		check({7'h0, bus_pullup_bit_out}, 8'h01);
		spi(4'hf, 4'h0, 8, rx);
		spi(4'hf, 4'h0, 8, rx);
		check({4'h0, rx[3:0]}, 8'h02);
		wr(4'h0, 4'h6);
		check({6'h0, mode_out}, 8'h02);
		dominant(WAKE + 10);
		check(resets[7:0], 8'h01);
		wr(4'h4, 4'h5);
		wr(4'h0, 4'h5);
		check({6'h0, rxd_follow_out, tx_enable_out}, 8'h02);
		dominant(WAKE + 10);
		check(wakes[7:0], 8'h01);
		for (int k = 0; k < 3; k++) begin
			ext_reset_n_in = (k != 0);
			por_in = (k == 1);
			reset_mode_in = (k == 2);
			step(6);
			ext_reset_n_in = 1'b1;
			por_in = 1'b0;
			reset_mode_in = 1'b0;
			step(6);
			check({4'h0, tx_enable_out, mode_out, slew_select_out[0]}, 8'h09);
			check({6'h0, slew_select_out}, 8'h01);
			wr(4'h4, 4'h2);
		end
		give_verdict();
	end
endmodule
